// ---- rtl/mcf_ctrl.sv ----
/*
 Master clock generation control and flash access waitstate timing.
 Assumes OSC_IN is asynchronous to CORE_CLK and a single AHB-Lite master.
*/
`timescale 1ns/1ps
`default_nettype none
module mcf_ctrl (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic OSC_IN,
	output logic MC_OUT,
	output logic CPU_CLK_OUT,
	input wire logic FLASH_REQ,
	input wire logic FLASH_SEQ,
	output logic FLASH_READY
);
	mcf_pkg::mcf_state_t st_reg, st_next;
	logic ref_tick;

	// Waitstate decode, reserved code treated as the slowest setting
	function automatic logic [1:0] ws_count(input logic [1:0] code);
		if (code > mcf_pkg::WS_MAX) begin
			ws_count = mcf_pkg::WS_MAX;
		end else begin
			ws_count = code;
		end
	endfunction

	// ****************************************
	// Reference tick
	// ****************************************
	// Input prescaler wrap, seen by the checks below; mirrors the next-state decode
	assign ref_tick = (st_reg.osc_sync[1] ^ st_reg.osc_sync[2]) && (st_reg.icnt >= st_reg.idiv);

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		logic edge_now;
		logic vco_tick;
		logic pre_tick;
		st_next = st_reg;
		edge_now = 1'b0;
		vco_tick = 1'b0;
		pre_tick = 1'b0;
		st_next.osc_sync = {st_reg.osc_sync[1:0], OSC_IN};
		// Stage one is read only by stage two
		// Both oscillator edges count, so the toggled master clock keeps the full ratio
		edge_now = st_reg.osc_sync[1] ^ st_reg.osc_sync[2];
		// Input prescaler on each oscillator edge
		if (edge_now) begin
			if (st_reg.icnt >= st_reg.idiv) begin
				st_next.icnt = 2'h0;
				pre_tick = 1'b1;
			end else begin
				st_next.icnt = st_reg.icnt + 2'h1;
			end
		end
		// ****************************************
		// Clock path
		// ****************************************
		// VCO model: multiply by (mul_eff+1) pulses per reference, band gates it
		// Limitation: those pulses must fit between two reference ticks in core cycles
		if (st_reg.mode == mcf_pkg::MODE_PLL && st_reg.vb == mcf_pkg::VB_RESERVED) begin
			// Reserved band holds the VCO still, master clock frozen
			vco_tick = 1'b0;
			st_next.vcnt = 5'h00;
			st_next.mul_eff = mcf_pkg::MUL_RST;
		end else if (st_reg.mode == mcf_pkg::MODE_PLL) begin
			if (pre_tick) begin
				st_next.vcnt = st_reg.mul_eff;
				vco_tick = 1'b1;
			end else if (st_reg.vcnt != 5'h00) begin
				st_next.vcnt = st_reg.vcnt - 5'h01;
				vco_tick = 1'b1;
			end
			// Multiplier glides toward its target one step per reference
			if (pre_tick && st_reg.mul_eff < st_reg.mul) begin
				st_next.mul_eff = st_reg.mul_eff + mcf_pkg::GLIDE_STEP;
			end else if (pre_tick && st_reg.mul_eff > st_reg.mul) begin
				st_next.mul_eff = st_reg.mul_eff - mcf_pkg::GLIDE_STEP;
			end
		end else begin
			vco_tick = pre_tick;
			st_next.vcnt = 5'h00;
			st_next.mul_eff = mcf_pkg::MUL_RST;
		end
		// Output prescaler toggles master clock
		if (vco_tick) begin
			if (st_reg.ocnt >= st_reg.odiv) begin
				st_next.ocnt = 4'h0;
				st_next.mc = ~st_reg.mc;
				if (!st_reg.halve || st_reg.mc) begin
					st_next.cpu = ~st_reg.cpu;
				end
			end else begin
				st_next.ocnt = st_reg.ocnt + 4'h1;
			end
		end
		// ****************************************
		// Flash access sequencer
		// ****************************************
		// Done pulse lasts one cycle unless a new access completes
		st_next.ready = 1'b0;
		case (st_reg.acc)
			mcf_pkg::MCF_IDLE: begin
				if (FLASH_REQ) begin
					if (FLASH_SEQ || ws_count(st_reg.ws) == 2'h0) begin
						st_next.ready = 1'b1;
					end else begin
						st_next.wcnt = ws_count(st_reg.ws) - 2'h1;
						st_next.acc = mcf_pkg::MCF_WAIT;
					end
				end
			end
			mcf_pkg::MCF_WAIT: begin
				if (st_reg.wcnt == 2'h0) begin
					st_next.ready = 1'b1;
					st_next.acc = mcf_pkg::MCF_IDLE;
				end else begin
					st_next.wcnt = st_reg.wcnt - 2'h1;
				end
			end
			default: st_next.acc = mcf_pkg::MCF_IDLE;
		endcase
		// ****************************************
		// Register bus
		// ****************************************
		// AHB-Lite: data phase of previous address phase
		if (st_reg.bus.act && st_reg.bus.wr) begin
			if (st_reg.bus.addr == mcf_pkg::CLK_CTRL_OFS) begin
				st_next.mode = HWDATA[mcf_pkg::MODE_POS +: 2];
				st_next.idiv = HWDATA[mcf_pkg::IDIV_POS +: 2];
				st_next.odiv = HWDATA[mcf_pkg::ODIV_POS +: 4];
				st_next.mul = HWDATA[mcf_pkg::MUL_POS +: 5];
				st_next.vb = HWDATA[mcf_pkg::VB_POS +: 2];
			end else if (st_reg.bus.addr == mcf_pkg::MEM_CTRL_OFS) begin
				st_next.ws = HWDATA[mcf_pkg::WS_POS +: 2];
			end else if (st_reg.bus.addr == mcf_pkg::SYS_CFG_OFS) begin
				st_next.halve = HWDATA[mcf_pkg::HALVE_POS];
			end
		end
		// Address phase capture and read data
		st_next.bus.act = HSEL && HREADY && HTRANS[1];
		st_next.bus.wr = HWRITE;
		st_next.bus.addr = HADDR[7:0];
		st_next.rdata = 32'h0000_0000;
		if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
			if (HADDR[7:0] == mcf_pkg::CLK_CTRL_OFS) begin
				st_next.rdata[mcf_pkg::MODE_POS +: 2] = st_reg.mode;
				st_next.rdata[mcf_pkg::IDIV_POS +: 2] = st_reg.idiv;
				st_next.rdata[mcf_pkg::ODIV_POS +: 4] = st_reg.odiv;
				st_next.rdata[mcf_pkg::MUL_POS +: 5] = st_reg.mul;
				st_next.rdata[mcf_pkg::VB_POS +: 2] = st_reg.vb;
			end else if (HADDR[7:0] == mcf_pkg::MEM_CTRL_OFS) begin
				st_next.rdata[mcf_pkg::WS_POS +: 2] = st_reg.ws;
			end else if (HADDR[7:0] == mcf_pkg::SYS_CFG_OFS) begin
				st_next.rdata[mcf_pkg::HALVE_POS] = st_reg.halve;
			end else if (HADDR[7:0] == mcf_pkg::STATUS_OFS) begin
				st_next.rdata[4:0] = st_reg.mul_eff;
				st_next.rdata[8] = (st_reg.mul_eff == st_reg.mul);
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			st_reg <= '0;
			st_reg.mode <= mcf_pkg::MODE_RST;
			st_reg.idiv <= mcf_pkg::IDIV_RST;
			st_reg.odiv <= mcf_pkg::ODIV_RST;
			st_reg.mul <= mcf_pkg::MUL_RST;
			st_reg.vb <= mcf_pkg::VB_RST;
			st_reg.ws <= mcf_pkg::WS_RST; // Slowest safe default
			st_reg.acc <= mcf_pkg::MCF_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flip-flops, HREADYOUT and HRESP tied constant; bus has zero wait states
	assign HRDATA = st_reg.rdata;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign MC_OUT = st_reg.mc;
	assign CPU_CLK_OUT = st_reg.cpu;
	assign FLASH_READY = st_reg.ready;

	// ****************************************
	// Assertions
	// ****************************************
	sequence ns_req;
		FLASH_REQ && !FLASH_SEQ && st_reg.acc == mcf_pkg::MCF_IDLE;
	endsequence
	// Data phase of a write to the memory control word
	sequence mem_write;
		st_reg.bus.act && st_reg.bus.wr && st_reg.bus.addr == mcf_pkg::MEM_CTRL_OFS;
	endsequence
	// Address phase of a read of the memory control word
	sequence mem_read;
		HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR[7:0] == mcf_pkg::MEM_CTRL_OFS;
	endsequence
	// Reference tick while the PLL path runs on a legal band
	sequence pll_ref;
		ref_tick && st_reg.mode == mcf_pkg::MODE_PLL && st_reg.vb != mcf_pkg::VB_RESERVED;
	endsequence
	ws_zero_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		ns_req and (st_reg.ws == 2'h0) |=> FLASH_READY) else $error("zero waitstate late");
	ws_two_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		ns_req and (st_reg.ws >= 2'h2) |=> !FLASH_READY ##1 !FLASH_READY ##1 FLASH_READY)
		else $error("two waitstates wrong");
	ws_one_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		ns_req and (st_reg.ws == 2'h1) |=> !FLASH_READY ##1 FLASH_READY) else $error("one waitstate wrong");
	seq_fast_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		FLASH_REQ && FLASH_SEQ && st_reg.acc == mcf_pkg::MCF_IDLE |=> FLASH_READY) else $error("sequential slow");
	glide_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		st_reg.mul_eff != $past(st_reg.mul_eff) |-> (st_reg.mul_eff - $past(st_reg.mul_eff) == 5'h01) ||
		($past(st_reg.mul_eff) - st_reg.mul_eff == 5'h01) || st_reg.mul_eff == 5'h00) else $error("abrupt step");
	bypass_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		st_reg.mode != mcf_pkg::MODE_PLL |=> st_reg.vcnt == 5'h00) else $error("vco used in bypass");
	halve_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		$changed(MC_OUT) && !$past(st_reg.halve) |-> $changed(CPU_CLK_OUT))
		else $error("cpu clock not following");
	cpu_half_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		$rose(MC_OUT) && $past(st_reg.halve) |-> $stable(CPU_CLK_OUT))
		else $error("halved cpu clock moved on rising master edge");
	band_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		st_reg.vb == mcf_pkg::VB_RESERVED |=> st_reg.vcnt == 5'h00) else $error("reserved band ran");
	odiv_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		st_reg.ocnt <= st_reg.odiv || $changed(st_reg.odiv) || $past(st_reg.ocnt) == st_reg.ocnt)
		else $error("prescaler overran");
	pll_load_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		pll_ref |=> st_reg.vcnt == $past(st_reg.mul_eff)) else $error("vco not reloaded in pll mode");
	band_stop_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		st_reg.mode == mcf_pkg::MODE_PLL && st_reg.vb == mcf_pkg::VB_RESERVED |=> $stable(MC_OUT))
		else $error("master clock ran on reserved band");
	bypass_mul_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		st_reg.mode != mcf_pkg::MODE_PLL |=> st_reg.mul_eff == 5'h00) else $error("multiplier kept in bypass");
	wait_quiet_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		st_reg.acc == mcf_pkg::MCF_WAIT |-> !FLASH_READY) else $error("done pulse during wait");
	wait_count_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		st_reg.acc == mcf_pkg::MCF_WAIT |-> st_reg.wcnt <= 2'h1) else $error("wait count beyond two");
	ws_write_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		mem_write |=> st_reg.ws == $past(HWDATA[1:0])) else $error("waitstate field not written");
	ws_read_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		mem_read |=> HRDATA[1:0] == $past(st_reg.ws)) else $error("waitstate field read wrong");
endmodule
`default_nettype wire

// ---- rtl/mcf_pkg.sv ----
/*
 Shared constants and types for the master clock and flash waitstate control.
 Assumes a single core clock domain and an AHB-Lite register bus.
*/
package mcf_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] CLK_CTRL_OFS = 8'h00;
	localparam logic [7:0] MEM_CTRL_OFS = 8'h04;
	localparam logic [7:0] SYS_CFG_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0C;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int MODE_POS = 0;
	localparam int IDIV_POS = 2;
	localparam int ODIV_POS = 4;
	localparam int MUL_POS = 8;
	localparam int VB_POS = 16;
	localparam int WS_POS = 0;
	localparam int HALVE_POS = 0;
	// ****************************************
	// Reset values and codes
	// ****************************************
	localparam logic [1:0] MODE_PLL = 2'h3;
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [1:0] IDIV_RST = 2'h0;
	localparam logic [3:0] ODIV_RST = 4'h0;
	localparam logic [4:0] MUL_RST = 5'h00;
	localparam logic [1:0] VB_RST = 2'h0;
	localparam logic [1:0] VB_RESERVED = 2'h3;
	localparam logic [1:0] WS_RST = 2'h2;
	localparam logic [1:0] WS_MAX = 2'h2;
	localparam logic [4:0] GLIDE_STEP = 5'h01;
	typedef enum {MCF_IDLE, MCF_WAIT} mcf_acc_t;
	// AHB-Lite data phase carrier
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic act;
	} mcf_bus_t;
	// Complete block state
	typedef struct packed {
		mcf_bus_t bus;
		logic [31:0] rdata;
		logic [1:0] mode;
		logic [1:0] idiv;
		logic [3:0] odiv;
		logic [4:0] mul;
		logic [1:0] vb;
		logic [1:0] ws;
		logic halve;
		logic [4:0] mul_eff;
		logic [1:0] icnt;
		logic [3:0] ocnt;
		logic [4:0] vcnt;
		logic mc;
		logic cpu;
		mcf_acc_t acc;
		logic [1:0] wcnt;
		logic ready;
		logic [2:0] osc_sync;
	} mcf_state_t;
endpackage

// ---- dv/mcf_osc_model.sv ----
/*
 Oscillator model driving the block's clock input.
 Assumes CORE_CLK samples it, so it runs well below the core rate.
*/
`timescale 1ns/1ps
`default_nettype none
module mcf_osc_model #(
	parameter int HALF_NS = 500
) (
	output logic OSC_OUT
);
	// Free running; the odd start offset keeps edges off CORE_CLK edges
	initial begin
		OSC_OUT = 1'b0;
		#13;
		forever #(HALF_NS) OSC_OUT = ~OSC_OUT;
	end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
/*
 Bench for mcf_ctrl: AHB-Lite access tasks, clock ratio counts and flash timing.
 Assumes a 1 MHz oscillator model and a single bus master.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin tests_run++; if ((g)!==(e)) begin failures++; $display("FAIL %s exp %0h got %0h",n,e,g); end end
module tb_top;
	logic clk = 0, rst = 1, hsel = 0, hwr = 0, req = 0, seq = 0;
	logic [31:0] ha = 0, hwd = 0, hrd, st;
	logic [1:0] htr = 0;
	logic rdy, resp, osc, mc, cpu, frdy;
	int failures = 0, tests_run = 0, cyc = 0, n, m, c;
	always #25 clk = ~clk;
	mcf_osc_model i_mcf_osc_model (.OSC_OUT(osc));
	mcf_ctrl i_mcf_ctrl (.CORE_CLK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(ha), .HTRANS(htr), .HWRITE(hwr),
		.HSIZE(3'h2), .HWDATA(hwd), .HREADY(rdy), .HRDATA(hrd), .HREADYOUT(rdy), .HRESP(resp), .OSC_IN(osc),
		.MC_OUT(mc), .CPU_CLK_OUT(cpu), .FLASH_REQ(req), .FLASH_SEQ(seq), .FLASH_READY(frdy));
	// ********
	// Tasks
	// ********
	// One single transfer; read data taken at the data phase edge
	task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		@(posedge clk);
		hsel <= 1; ha <= a; hwr <= w; htr <= 2'h2;
		do @(posedge clk); while (rdy !== 1'b1);
		htr <= 2'h0; hsel <= 0; hwd <= d;
		do @(posedge clk); while (rdy !== 1'b1);
		r = hrd;
	endtask
	// Pulse counting is coarse, so allow a small slack around the ideal
	function automatic int near(int v, int e);
		return (v >= e - 2 - e / 50 && v <= e + 2 + e / 50) ? e : v;
	endfunction
	// Program the clock, wait for lock where it applies, count edges
	task automatic meas(input logic [31:0] cfg, input logic h, input int emc, input int ecp);
		logic pm, pc;
		bus(1, 32'h0000_0000, cfg, st);
		bus(1, 32'h0000_0008, {31'h0, h}, st);
		if (cfg[1:0] == 2'h3 && cfg[17:16] != 2'h3) begin
			n = 0;
			do begin bus(0, 32'h0000_000C, 0, st); n++; end
			while (!(st[8] === 1'b1 && st[4:0] === cfg[12:8]) && n < 300);
			`CHK("mul_eff", cfg[12:8], st[4:0])
		end
		m = 0; c = 0; pm = mc; pc = cpu;
		repeat (2000) begin
			@(posedge clk); #1;
			m += (mc && !pm);
			c += (cpu && !pc);
			pm = mc; pc = cpu;
		end
		`CHK("mc_edges", emc, near(m, emc))
		`CHK("cpu_edges", ecp, near(c, ecp))
	endtask
	// Request is taken at one edge; count edges until the done pulse
	task automatic flash(input logic s, input int e);
		@(posedge clk);
		req <= 1; seq <= s;
		@(posedge clk);
		req <= 0; n = 1;
		#1;
		while (frdy !== 1'b1 && n < 20) begin @(posedge clk); #1; n++; end
		`CHK("flash_cycles", e, n)
	endtask
	task automatic summarize;
		if (failures == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ********
	// Sequence
	// ********
	// Run length is a few thousand cycles per ratio count
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			summarize;
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 0;
		bus(0, 32'h0000_0000, 0, st);
		`CHK("clk_ctrl_rst", 32'h0000_0000, st)
		bus(0, 32'h0000_0004, 0, st);
		`CHK("ws_rst", 32'h0000_0002, st)
		bus(0, 32'h0000_0040, 0, st);
		`CHK("unmapped", 32'h0000_0000, st)
		// Every waitstate code, reserved one included
		for (int w = 0; w < 4; w++) begin
			bus(1, 32'h0000_0004, w, st);
			flash(0, 1 + (w > 2 ? 2 : w));
		end
		flash(1, 1);
		meas(32'h0000_0000, 0, 100, 100);
		meas(32'h0000_0044, 0, 10, 10);
		// Large jump in multiplier must not land at once
		bus(1, 32'h0000_0000, 32'h0000_1F03, st);
		bus(0, 32'h0000_000C, 0, st);
		`CHK("glide", 1'b1, st[4:0] != 5'h1F)
		// PLL times two over every band; reserved band stops the VCO
		for (int b = 0; b < 4; b++) begin
			meas(32'h0000_0313 | (b << 16), 0, b == 3 ? 0 : 200, b == 3 ? 0 : 200);
		end
		meas(32'h0000_0313, 1, 200, 100);
		summarize;
	end
endmodule
`default_nettype wire
